/* File: logic/block_receiver_device.sv */
// receiver half of the multiprocessor link adapter
// assumes in-out bus, mask strobe, link offer and data channel all run on clock
// Function
// R1: four-bit jumper identity shared by both halves
// R2: address load takes accumulator bits 1-15
// R3: software loads negative or zero word count
// R4: address reads with bit 0 zero; count whole
// R5: device code 7, bits 8-9 select function
// R6: interrupt disable follows mask bit 12
// R7: status bits 0-3 give own identity
// R8: status bits 4-7 give linked sender identity
// R9: timeout flag after 10 ms without data
// R10: status bit 13 shows lock
// R11: bits 14/15 show sender/receiver count finished
// R12: start clears done, flags 12,14,15; sets busy
// R13: clear drops busy, done, flags 12-15
// R14: end event clears busy, sets done, interrupts
// R15: lock onto first sender while busy
// R16: locked receiver refuses all other senders
// R17: store word at address, bump both counters
// R18: no new word until previous stored
// R19: either count overflow ends block
// R20: 2 us round robin cycle on bus
// R21: refused word is offered again later
// R22: no-data timer restarts on each word
`timescale 1ns/10ps
`include "rx_link_params.svh"

module block_receiver_device #(
    parameter int unsigned TIMEOUT_CYCLES = `RX_TIMEOUT_CYCLES  // no-data limit in clocks
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [`RX_ID_W-1:0] node_id,          // jumper identity
    input wire logic io_strobe,                      // one-cycle in-out instruction
    input wire logic [`RX_DEV_W-1:0] io_dev_code,     // device select
    input wire rx_link_pkg::xfer_t io_xfer,          // transfer field
    input wire rx_link_pkg::func_t io_func,          // function field
    input wire logic [`RX_WORD_W-1:0] io_data_in,     // working_accumulator out
    output logic [`RX_WORD_W-1:0] io_data_out,        // working_accumulator in
    input wire logic mask_strobe,                    // priority mask write
    input wire logic [`RX_WORD_W-1:0] mask_data,
    output logic busy,
    output logic done,
    output logic irq_request,
    input wire logic link_valid,                     // word offered this bus turn
    input wire logic [`RX_ID_W-1:0] link_src_id,
    input wire logic [`RX_ID_W-1:0] link_dst_id,
    input wire logic [`RX_WORD_W-1:0] link_word,
    input wire logic link_sender_last,              // sender count ends with this word
    output logic link_accept,
    output logic dch_valid,                          // data channel write request
    input wire logic dch_ready,
    output logic [`RX_ADDR_W-1:0] dch_addr,
    output logic [`RX_WORD_W-1:0] dch_data
);
    import rx_link_pkg::*;

    localparam logic [`RX_TMO_W-1:0] TMO_LAST = `RX_TMO_W'(TIMEOUT_CYCLES - 1);

    // control and status state
    logic busy_reg, busy_next;
    logic done_reg, done_next;
    logic lock_reg, lock_next;                       // status bit 13
    logic tmo_reg, tmo_next;                         // status bit 12
    logic snd_fin_reg, snd_fin_next;                 // sender_count_finished
    logic rcv_fin_reg, rcv_fin_next;                 // receiver_count_finished
    logic int_dis_reg, int_dis_next;
    logic [`RX_ID_W-1:0] peer_id_reg, peer_id_next;  // linked sender
    logic [`RX_ADDR_W-1:0] addr_reg, addr_next;      // rx_block_address
    logic [`RX_WORD_W-1:0] count_reg, count_next;    // rx_word_count
    logic [`RX_TMO_W-1:0] tmo_cnt_reg, tmo_cnt_next; // no-data timer
    logic [`RX_WORD_W-1:0] rd_reg, rd_next;          // read-back latch

    // decoded instruction and events
    logic hit, cmd_start, cmd_clear, ld_addr, ld_count;
    logic can_take, ev_tmo, ev_snd, ev_rcv, ev_any;
    logic [`RX_WORD_W-1:0] status_word;
    logic buf_in_ready, buf_empty;
    buf_word_t buf_out;

    // instruction select on device code
    assign hit = io_strobe && (io_dev_code == `RX_DEV_CODE);  // [R5]
    assign cmd_start = hit && (io_func == `RX_FN_START);       // [R5]
    assign cmd_clear = hit && (io_func == `RX_FN_CLEAR);       // [R5]
    assign ld_addr = hit && (io_xfer == `RX_XF_LD_ADDR);
    assign ld_count = hit && (io_xfer == `RX_XF_LD_COUNT);

    // accept only an addressed word, enabled, buffer drained, right sender
    assign can_take = busy_reg && !cmd_clear && buf_empty && buf_in_ready  // [R18]
        && link_valid && (link_dst_id == node_id)
        && (!lock_reg || (link_src_id == peer_id_reg));      // [R15] [R16]
    // an unaccepted offer is simply left for the sender's next turn
    assign link_accept = can_take;                           // [R20] [R21]

    // end-of-block events
    assign ev_rcv = can_take && (count_reg == `RX_COUNT_LAST);  // [R19]
    assign ev_snd = can_take && link_sender_last;              // [R19]
    assign ev_tmo = busy_reg && lock_reg && !can_take && !cmd_clear
        && (tmo_cnt_reg == TMO_LAST);                        // [R9]
    assign ev_any = ev_rcv || ev_snd || ev_tmo;

    // status word: own code, peer code, flags
    always_comb begin
        status_word = '0;
        status_word[`RX_ST_OWN_HI:`RX_ST_OWN_LO] = node_id;        // [R1] [R7]
        status_word[`RX_ST_PEER_HI:`RX_ST_PEER_LO] = peer_id_reg;  // [R8]
        status_word[`RX_ST_TIMEOUT] = tmo_reg;                     // [R9]
        status_word[`RX_ST_LOCK] = lock_reg;                       // [R10]
        status_word[`RX_ST_SND_FIN] = snd_fin_reg;                 // [R11]
        status_word[`RX_ST_RCV_FIN] = rcv_fin_reg;                 // [R11]
    end

    // flag logic: functions first, hardware events override
    always_comb begin
        busy_next = busy_reg;
        done_next = done_reg;
        lock_next = lock_reg;
        tmo_next = tmo_reg;
        snd_fin_next = snd_fin_reg;
        rcv_fin_next = rcv_fin_reg;
        peer_id_next = peer_id_reg;
        int_dis_next = int_dis_reg;
        // interrupt disable tracks its mask bit
        if (mask_strobe) begin
            int_dis_next = mask_data[`RX_MASK_BIT];          // [R6]
        end
        if (cmd_start) begin
            busy_next = 1'b1;                                // [R12]
            done_next = 1'b0;
            tmo_next = 1'b0;
            snd_fin_next = 1'b0;
            rcv_fin_next = 1'b0;
        end else if (cmd_clear) begin
            busy_next = 1'b0;                                // [R13]
            done_next = 1'b0;
            tmo_next = 1'b0;
            lock_next = 1'b0;
            snd_fin_next = 1'b0;
            rcv_fin_next = 1'b0;
        end
        // first accepted word locks the link
        if (can_take && !lock_reg) begin
            lock_next = 1'b1;                                // [R15]
            peer_id_next = link_src_id;                      // [R8]
        end
        // events win over a same-cycle function, lock kept
        if (ev_tmo) begin
            tmo_next = 1'b1;
        end
        if (ev_snd) begin
            snd_fin_next = 1'b1;
        end
        if (ev_rcv) begin
            rcv_fin_next = 1'b1;
        end
        if (ev_any) begin
            busy_next = 1'b0;                                // [R14]
            done_next = 1'b1;
        end
    end

    // counters: loads from accumulator, step on each accepted word
    always_comb begin
        addr_next = addr_reg;
        count_next = count_reg;
        if (can_take) begin
            addr_next = addr_reg + `RX_ADDR_ONE;             // [R17]
            count_next = count_reg + `RX_COUNT_ONE;          // [R17] [R3]
        end
        if (ld_addr) begin
            addr_next = io_data_in[`RX_ADDR_W-1:0];          // [R2]
        end
        if (ld_count) begin
            count_next = io_data_in;
        end
    end

    // no-data timer: runs while busy and locked, restarts on a word
    always_comb begin
        tmo_cnt_next = tmo_cnt_reg;
        if (!(busy_reg && lock_reg) || can_take || ev_tmo) begin
            tmo_cnt_next = `RX_TMO_ZERO;                     // [R22]
        end else begin
            tmo_cnt_next = tmo_cnt_reg + `RX_TMO_ONE;        // [R22]
        end
    end

    // read-back latch for in-out data transfers
    always_comb begin
        rd_next = rd_reg;
        if (hit) begin
            case (io_xfer)
                `RX_XF_RD_ADDR: rd_next = {1'b0, addr_reg};  // [R4]
                `RX_XF_RD_COUNT: rd_next = count_reg;        // [R4]
                `RX_XF_RD_STATUS: rd_next = status_word;
                default: rd_next = rd_reg;
            endcase
        end
    end

    // register all state
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            lock_reg <= 1'b0;
            tmo_reg <= 1'b0;
            snd_fin_reg <= 1'b0;
            rcv_fin_reg <= 1'b0;
            int_dis_reg <= 1'b0;
            peer_id_reg <= `RX_ID_RST;
            addr_reg <= `RX_ADDR_RST;
            count_reg <= `RX_COUNT_RST;
            tmo_cnt_reg <= `RX_TMO_ZERO;
            rd_reg <= `RX_COUNT_RST;
        end else begin
            busy_reg <= busy_next;
            done_reg <= done_next;
            lock_reg <= lock_next;
            tmo_reg <= tmo_next;
            snd_fin_reg <= snd_fin_next;
            rcv_fin_reg <= rcv_fin_next;
            int_dis_reg <= int_dis_next;
            peer_id_reg <= peer_id_next;
            addr_reg <= addr_next;
            count_reg <= count_next;
            tmo_cnt_reg <= tmo_cnt_next;
            rd_reg <= rd_next;
        end
    end

    // word path to the data channel through the two-entry buffer
    rx_word_buffer u_buffer (
        .clock(clock),
        .resetn(resetn),
        .in_valid(can_take),                                 // [R17]
        .in_ready(buf_in_ready),
        .in_data({addr_reg, link_word}),
        .out_valid(dch_valid),
        .out_ready(dch_ready),
        .out_data(buf_out),
        .empty(buf_empty)
    );

    assign dch_addr = buf_out[`RX_BUF_W-1:`RX_WORD_W];
    assign dch_data = buf_out[`RX_WORD_W-1:0];
    assign io_data_out = rd_reg;
    assign busy = busy_reg;
    assign done = done_reg;
    assign irq_request = done_reg && !int_dis_reg;           // [R14]

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence s_first_word;
        link_accept && !lock_reg;
    endsequence

    sequence s_locked_to_source;
        lock_reg && (peer_id_reg == $past(link_src_id));
    endsequence

    a_lock_first_word: assert property (s_first_word |=> s_locked_to_source)  // [R15]
        else $error("lock not taken on first word");
    a_locked_source: assert property (link_accept && lock_reg |-> link_src_id == peer_id_reg)  // [R16]
        else $error("word taken from foreign sender");
    a_accept_busy: assert property (link_accept |-> busy_reg && link_dst_id == node_id)  // [R15]
        else $error("word taken while not enabled");
    a_one_in_flight: assert property (link_accept |-> buf_empty ##1 !link_accept)  // [R18]
        else $error("word taken before previous stored");
    a_counter_step: assert property (link_accept && !ld_addr && !ld_count |=>
        addr_reg == $past(addr_reg) + `RX_ADDR_ONE && count_reg == $past(count_reg) + `RX_COUNT_ONE)  // [R17]
        else $error("counters did not step");
    a_count_wrap: assert property (link_accept && count_reg == `RX_COUNT_LAST |=>
        rcv_fin_reg && done_reg && !busy_reg && lock_reg)  // [R19]
        else $error("own count overflow did not end block");
    // a first word taken in the start cycle may lock legally, so that cycle is left out
    a_start_effect: assert property (cmd_start && !ev_any && !link_accept |=>
        busy_reg && !done_reg && !tmo_reg && !snd_fin_reg && !rcv_fin_reg && lock_reg == $past(lock_reg))  // [R12]
        else $error("start function wrong");
    a_clear_effect: assert property (cmd_clear |=> !busy_reg && !done_reg && !lock_reg && !tmo_reg)  // [R13]
        else $error("clear function wrong");
    a_done_irq: assert property (ev_any && !int_dis_reg && !mask_strobe |=> done_reg ##0 irq_request)  // [R14]
        else $error("end event gave no interrupt");
    a_timeout_cause: assert property ($rose(tmo_reg) |-> $past(busy_reg && lock_reg && !link_accept))  // [R9]
        else $error("timeout without idle locked transfer");
    a_read_addr: assert property (hit && io_xfer == `RX_XF_RD_ADDR |=>
        io_data_out == {1'b0, $past(addr_reg)})  // [R4]
        else $error("address read-back wrong");
endmodule : block_receiver_device

/* File: logic/rx_link_params.svh */
// constants for the block receiver: device decode, field positions, timing
// assumes inclusion by the package and the design files through its bare name
`ifndef RX_LINK_PARAMS_SVH
`define RX_LINK_PARAMS_SVH

// device select code of the receiver on the in-out bus
`define RX_DEV_CODE 6'h07
`define RX_DEV_W 6

// transfer field codes (instruction bits 5 to 7)
`define RX_XF_NONE 3'h0
`define RX_XF_RD_ADDR 3'h1
`define RX_XF_LD_ADDR 3'h2
`define RX_XF_RD_COUNT 3'h3
`define RX_XF_LD_COUNT 3'h4
`define RX_XF_RD_STATUS 3'h5

// function field codes (instruction bits 8 and 9)
`define RX_FN_NONE 2'h0
`define RX_FN_START 2'h1
`define RX_FN_CLEAR 2'h2
`define RX_FN_PULSE 2'h3

// word layout: bus bits count from the top, so bus bit 0 is bit 15 here
`define RX_WORD_W 16
`define RX_ADDR_W 15
`define RX_ID_W 4
`define RX_ST_OWN_HI 15
`define RX_ST_OWN_LO 12
`define RX_ST_PEER_HI 11
`define RX_ST_PEER_LO 8
`define RX_ST_TIMEOUT 3
`define RX_ST_LOCK 2
`define RX_ST_SND_FIN 1
`define RX_ST_RCV_FIN 0
`define RX_MASK_BIT 3

// reset values, last count and counter steps
`define RX_ADDR_RST 15'h0000
`define RX_COUNT_RST 16'h0000
`define RX_ID_RST 4'h0
`define RX_COUNT_LAST 16'hffff
`define RX_ADDR_ONE 15'h0001
`define RX_COUNT_ONE 16'h0001

// timing: 20 MHz clock, 10 ms no-data limit
`define RX_CLK_PERIOD_NS 50
`define RX_TIMEOUT_NS 10000000
`define RX_TIMEOUT_CYCLES (`RX_TIMEOUT_NS / `RX_CLK_PERIOD_NS)
`define RX_TMO_W 18
`define RX_TMO_ZERO 18'h00000
`define RX_TMO_ONE 18'h00001

// buffer entry: address then data word
`define RX_BUF_W 31

`endif

/* File: logic/rx_link_pkg.sv */
// types shared by the block receiver and its buffer
// assumes the constant header is on the include path
`include "rx_link_params.svh"

package rx_link_pkg;
    // in-out transfer selected by instruction bits 5 to 7
    typedef logic [2:0] xfer_t;
    // busy and done function selected by instruction bits 8 and 9
    typedef logic [1:0] func_t;
    // a stored word together with its memory address
    typedef logic [`RX_BUF_W-1:0] buf_word_t;
endpackage : rx_link_pkg

/* File: logic/rx_word_buffer.sv */
// two-entry buffer between the link side and the data channel
// assumes one clock; the drain side may stall for any number of cycles
`timescale 1ns/10ps

module rx_word_buffer (
    input wire logic clock,
    input wire logic resetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire rx_link_pkg::buf_word_t in_data,
    output logic out_valid,
    input wire logic out_ready,
    output rx_link_pkg::buf_word_t out_data,
    output logic empty
);
    import rx_link_pkg::*;

    buf_word_t mem_reg [2];         // entry storage
    buf_word_t mem_next [2];
    logic wr_ptr_reg, wr_ptr_next;  // index of next free entry
    logic rd_ptr_reg, rd_ptr_next;  // index of oldest entry
    logic [1:0] fill_reg, fill_next; // number of entries held
    logic push, pop;

    // honest full and empty flags from the fill level
    assign in_ready = (fill_reg != 2'h2);
    assign out_valid = (fill_reg != 2'h0);
    assign empty = (fill_reg == 2'h0);
    assign out_data = mem_reg[rd_ptr_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // next pointers, level and contents
    always_comb begin
        mem_next = mem_reg;
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        fill_next = fill_reg;
        if (push) begin
            mem_next[wr_ptr_reg] = in_data;
            wr_ptr_next = ~wr_ptr_reg;
        end
        if (pop) begin
            rd_ptr_next = ~rd_ptr_reg;
        end
        // level moves only when one side acts alone
        if (push && !pop) begin
            fill_next = fill_reg + 2'h1;
        end else if (pop && !push) begin
            fill_next = fill_reg - 2'h1;
        end
    end

    // register stage
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            fill_reg <= 2'h0;
        end else begin
            mem_reg <= mem_next;
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            fill_reg <= fill_next;
        end
    end
endmodule : rx_word_buffer

/* File: verif/multiproc_block_receiver_test.sv */
// self-checking bench for the block receiver with a remote sender model
// assumes the design package and the sender model are compiled first
`timescale 1ns/10ps

module multiproc_block_receiver_test;
    import rx_link_pkg::*;
    localparam int TMO = 200;  // shortened no-data limit, still longer than a few bus turns
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] node_id = 4'ha;  // own jumper identity
    logic io_strobe = 1'b0;
    logic [5:0] io_dev_code = 6'h07;
    xfer_t io_xfer = 3'h0;
    func_t io_func = 2'h0;
    logic [15:0] io_data_in = 16'h0000;
    logic [15:0] io_data_out;
    logic mask_strobe = 1'b0;
    logic [15:0] mask_data = 16'h0000;
    logic busy, done, irq_request, link_valid, link_sender_last, link_accept, dch_valid;
    logic [3:0] link_src_id, link_dst_id;
    logic [15:0] link_word, dch_data, v;
    logic [14:0] dch_addr;
    logic dch_ready = 1'b0;
    logic stall = 1'b0;  // data channel refuses while set
    logic [30:0] writes[$];  // stored address and word pairs
    int err_count = 0;
    int checks_done = 0;
    bit ok;

    // free-running clock, 50 ns period
    always #25 clock = ~clock;

    block_receiver_device #(.TIMEOUT_CYCLES(TMO)) dut_u (
        .clock(clock), .resetn(resetn), .node_id(node_id), .io_strobe(io_strobe),
        .io_dev_code(io_dev_code), .io_xfer(io_xfer), .io_func(io_func), .io_data_in(io_data_in),
        .io_data_out(io_data_out), .mask_strobe(mask_strobe), .mask_data(mask_data), .busy(busy),
        .done(done), .irq_request(irq_request), .link_valid(link_valid), .link_src_id(link_src_id),
        .link_dst_id(link_dst_id), .link_word(link_word), .link_sender_last(link_sender_last),
        .link_accept(link_accept), .dch_valid(dch_valid), .dch_ready(dch_ready),
        .dch_addr(dch_addr), .dch_data(dch_data)
    );

    remote_sender_model #(.TURN(40)) partner_u (
        .clock(clock), .link_accept(link_accept), .link_valid(link_valid),
        .link_src_id(link_src_id), .link_dst_id(link_dst_id), .link_word(link_word),
        .link_sender_last(link_sender_last)
    );

    // memory side: set ready for the coming edge, then record the write that edge completes
    always @(negedge clock) begin
        dch_ready = !stall;
        if (dch_valid === 1'b1 && dch_ready === 1'b1) begin
            writes.push_back({dch_addr, dch_data});
        end
    end

    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one in-out instruction; the answer is settled when the task returns
    task automatic io(input logic [2:0] x, input logic [1:0] f, input logic [15:0] d);
        @(negedge clock);
        io_strobe = 1'b1;
        io_xfer = x;
        io_func = f;
        io_data_in = d;
        @(negedge clock);
        io_strobe = 1'b0;
        io_xfer = 3'h0;
        io_func = 2'h0;
        v = io_data_out;
    endtask : io

    // priority mask write
    task automatic mask(input logic [15:0] m);
        @(negedge clock);
        mask_strobe = 1'b1;
        mask_data = m;
        @(negedge clock);
        mask_strobe = 1'b0;
    endtask : mask

    // expected status word: flags are timeout, lock, sender done, receiver done
    function automatic logic [15:0] st(input logic [3:0] peer, input logic [3:0] fl);
        return {node_id, peer, 4'h0, fl};
    endfunction : st

    // reset values, counter loads and reads, foreign device code
    task automatic t_regs;
        io(3'h5, 2'h0, 16'h0000);
        chk(v, st(4'h0, 4'h0));
        chk({busy, done, irq_request}, 3'h0);
        io(3'h2, 2'h0, 16'hfffe);
        io(3'h1, 2'h0, 16'h0000);
        chk(v, 16'h7ffe);
        io_dev_code = 6'h06;
        io(3'h2, 2'h1, 16'h0123);
        io_dev_code = 6'h07;
        io(3'h1, 2'h0, 16'h0000);
        chk({v, busy}, {16'h7ffe, 1'b0});
        io(3'h4, 2'h0, 16'h8001);
        io(3'h3, 2'h0, 16'h0000);
        chk(v, 16'h8001);
    endtask : t_regs

    // two-word block ending on own count, with a stalled data channel
    task automatic t_block;
        io(3'h2, 2'h0, 16'h0100);
        io(3'h4, 2'h1, 16'hfffe);  // minus two words
        chk({busy, done}, 2'h2);
        stall = 1'b1;
        partner_u.send(4'h3, node_id, 16'h1111, 1'b0, 1, ok);
        chk(ok, 1'b1);
        partner_u.send(4'h3, node_id, 16'h2222, 1'b0, 1, ok);
        chk(ok, 1'b0);
        stall = 1'b0;
        partner_u.send(4'h5, node_id, 16'h5555, 1'b0, 1, ok);
        chk(ok, 1'b0);
        partner_u.send(4'h3, node_id, 16'h2222, 1'b0, 3, ok);
        chk(ok, 1'b1);
        repeat (4) @(negedge clock);
        chk(writes.size(), 2);
        chk(writes[0], {15'h0100, 16'h1111});
        chk(writes[1], {15'h0101, 16'h2222});
        io(3'h5, 2'h0, 16'h0000);
        chk(v, st(4'h3, 4'h5));
        chk({busy, done, irq_request}, 3'h3);
        io(3'h1, 2'h0, 16'h0000);
        chk(v, 16'h0102);
        io(3'h3, 2'h0, 16'h0000);
        chk(v, 16'h0000);
    endtask : t_block

    // restart while locked, end on the sender's count, interrupt masked
    task automatic t_sender_end;
        mask(16'h0008);
        io(3'h4, 2'h1, 16'h0000);  // zero count takes any block size
        io(3'h5, 2'h0, 16'h0000);
        chk(v, st(4'h3, 4'h4));
        partner_u.send(4'h6, node_id, 16'h6666, 1'b0, 1, ok);
        chk(ok, 1'b0);
        partner_u.send(4'h3, node_id, 16'h3333, 1'b1, 1, ok);
        chk(ok, 1'b1);
        io(3'h5, 2'h0, 16'h0000);
        chk(v, st(4'h3, 4'h6));
        chk({busy, done, irq_request}, 3'h2);
        mask(16'h0000);
        chk(irq_request, 1'b1);
    endtask : t_sender_end

    // locked and busy with no data: timeout after the limit, not before
    task automatic t_timeout;
        io(3'h0, 2'h1, 16'h0000);
        repeat (TMO - 4) @(negedge clock);
        chk({busy, done}, 2'h2);
        repeat (10) @(negedge clock);
        io(3'h5, 2'h0, 16'h0000);
        chk(v, st(4'h3, 4'hc));
        chk({busy, done}, 2'h1);
    endtask : t_timeout

    // clear unlocks; the next block locks onto a new sender
    task automatic t_clear;
        io(3'h0, 2'h2, 16'h0000);
        io(3'h5, 2'h0, 16'h0000);
        chk(v, st(4'h3, 4'h0));
        chk({busy, done, irq_request}, 3'h0);
        partner_u.send(4'h5, node_id, 16'h5555, 1'b0, 1, ok);
        chk(ok, 1'b0);
        io(3'h4, 2'h1, 16'hffff);  // minus one word
        partner_u.send(4'h5, 4'h2, 16'h5555, 1'b0, 1, ok);
        chk(ok, 1'b0);
        partner_u.send(4'h5, node_id, 16'h5555, 1'b0, 1, ok);
        chk(ok, 1'b1);
        io(3'h5, 2'h0, 16'h0000);
        chk(v, st(4'h5, 4'h5));
        repeat (2) @(negedge clock);
        chk(writes[writes.size() - 1], {15'h0103, 16'h5555});
    endtask : t_clear

    // verdict and end of run
    task automatic end_sim;
        if (err_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    // main sequence: reset for two cycles, then the scenarios
    initial begin
        repeat (2) @(negedge clock);
        resetn = 1'b1;
        t_regs();
        t_block();
        t_sender_end();
        t_timeout();
        t_clear();
        end_sim();
    end

    // watchdog, well beyond the few hundred cycles the scenarios need
    initial begin
        #(20000 * 50);
        err_count++;
        end_sim();
    end
endmodule : multiproc_block_receiver_test

/* File: verif/remote_sender_model.sv */
// remote sender on the shared link bus: offers one word per bus turn
// assumes the receiver samples the offer at the rising clock edge
`timescale 1ns/10ps

module remote_sender_model #(
    parameter int TURN = 40  // cycles between bus turns, 2 us at 50 ns
) (
    input wire logic clock,
    input wire logic link_accept,
    output logic link_valid,
    output logic [3:0] link_src_id,
    output logic [3:0] link_dst_id,
    output logic [15:0] link_word,
    output logic link_sender_last
);
    // idle bus before any offer
    initial begin
        link_valid = 1'b0;
        link_src_id = 4'h0;
        link_dst_id = 4'h0;
        link_word = 16'h0000;
        link_sender_last = 1'b0;
    end

    // offer the same word once per turn until taken or the tries run out
    task automatic send(input logic [3:0] src, input logic [3:0] dst, input logic [15:0] word,
                        input logic last, input int tries, output bit ok);
        ok = 1'b0;
        for (int t = 0; t < tries && !ok; t++) begin
            @(negedge clock);
            link_valid = 1'b1;
            link_src_id = src;
            link_dst_id = dst;
            link_word = word;
            link_sender_last = last;
            #20;
            // offer is held across the rising edge that takes it
            ok = link_accept;
            @(negedge clock);
            link_valid = 1'b0;
            // released lines show the inverse so a stale value never passes
            link_src_id = ~src;
            link_dst_id = ~dst;
            link_word = ~word;
            link_sender_last = ~last;
            if (!ok) begin
                repeat (TURN - 2) @(negedge clock);  // wait for the next turn, same word
            end
        end
    endtask : send
endmodule : remote_sender_model
